// ==== design/fsd_top.sv ====
// four-digit seven-segment decoder, digit latches and backplane generator
// all pins asynchronous to i_ref_clk; timebase pin is sampled, not used as a clock
`include "fsd_consts.svh"
module fsd_top
	import fsd_pkg::*;
#(
	parameter fsd_front_t FRONT = FSD_FRONT_CPU,
	parameter fsd_decode_t DECODE = FSD_DECODE_HEX,
	parameter bit LED_VARIANT = 1'b0
) (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic [3:0] i_value,
	input wire logic i_digit_addr_low,
	input wire logic i_digit_addr_high,
	input wire logic i_chip_select_first_n,
	input wire logic i_chip_select_second_n,
	input wire logic [3:0] i_digit_strobe,
	input wire logic i_timebase_pin,
	input wire logic i_backplane,
	input wire logic i_brightness,
	output logic o_backplane,
	output logic o_backplane_oe_n,
	output logic [27:0] o_segment
);
	localparam int SLOW_W = $clog2(`FSD_SLAVE_LOW_CYC + 1);
	localparam int DIV_W = $clog2(`FSD_BP_DIV);

	// seven-segment patterns, bit 0 = a ... bit 6 = g
	function automatic fsd_seg_t fsd_decode(input logic [3:0] v, input fsd_decode_t mode);
		fsd_seg_t s;
		s = 7'h00;
		unique case (v)
			4'h0: s = 7'h3F;
			4'h1: s = 7'h06;
			4'h2: s = 7'h5B;
			4'h3: s = 7'h4F;
			4'h4: s = 7'h66;
			4'h5: s = 7'h6D;
			4'h6: s = 7'h7D;
			4'h7: s = 7'h07;
			4'h8: s = 7'h7F;
			4'h9: s = 7'h6F;
			4'hA: s = (mode == FSD_DECODE_HEX) ? 7'h77 : 7'h40;
			4'hB: s = (mode == FSD_DECODE_HEX) ? 7'h7C : 7'h79;
			4'hC: s = (mode == FSD_DECODE_HEX) ? 7'h39 : 7'h76;
			4'hD: s = (mode == FSD_DECODE_HEX) ? 7'h5E : 7'h38;
			4'hE: s = (mode == FSD_DECODE_HEX) ? 7'h79 : 7'h73;
			4'hF: s = (mode == FSD_DECODE_HEX) ? 7'h71 : 7'h00;
		endcase
		return s;
	endfunction

	// one-hot digit write enable from the latched address; bit 0 = digit one
	function automatic logic [3:0] fsd_addr_onehot(input logic [1:0] a);
		logic [3:0] w;
		w = 4'h0;
		unique case (a)
			`FSD_ADDR_DIGIT4: w = 4'h8;
			`FSD_ADDR_DIGIT3: w = 4'h4;
			`FSD_ADDR_DIGIT2: w = 4'h2;
			`FSD_ADDR_DIGIT1: w = 4'h1;
		endcase
		return w;
	endfunction

	// two-stage synchronisers for every pin
	// nothing reads a first stage: every pin is asynchronous to the reference clock
	logic [3:0] val_s1_r, val_r;
	logic [1:0] addr_s1_r, addr_r;
	logic [1:0] cs_s1_r, cs_n_r;
	logic [3:0] stb_s1_r, stb_r;
	logic [2:0] misc_s1_r, misc_r;

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			val_s1_r <= 4'h0;
			val_r <= 4'h0;
			addr_s1_r <= 2'h0;
			addr_r <= 2'h0;
			cs_s1_r <= 2'h3;
			cs_n_r <= 2'h3;
			stb_s1_r <= 4'h0;
			stb_r <= 4'h0;
			misc_s1_r <= 3'h1;
			misc_r <= 3'h1;
		end else if (i_ce) begin
			val_s1_r <= i_value;
			val_r <= val_s1_r;
			addr_s1_r <= {i_digit_addr_high, i_digit_addr_low};
			addr_r <= addr_s1_r;
			cs_s1_r <= {i_chip_select_second_n, i_chip_select_first_n};
			cs_n_r <= cs_s1_r;
			stb_s1_r <= i_digit_strobe;
			stb_r <= stb_s1_r;
			misc_s1_r <= {i_brightness, i_backplane, i_timebase_pin};
			misc_r <= misc_s1_r;
		end
	end

	wire tb_sync = misc_r[0];
	wire bp_in_sync = misc_r[1];
	wire bright_sync = misc_r[2];

	// processor front end: holding latches follow while both selects low
	logic [3:0] hold_val_r;
	logic [1:0] hold_addr_r;
	logic sel_both_r;
	wire sel_both = ~cs_n_r[0] & ~cs_n_r[1];
	wire cs_rise = sel_both_r & ~sel_both;

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			hold_val_r <= 4'h0;
			hold_addr_r <= 2'h0;
			sel_both_r <= 1'b0;
		end else if (i_ce) begin
			sel_both_r <= sel_both;
			if (sel_both) begin
				hold_val_r <= val_r;
				hold_addr_r <= addr_r;
			end
		end
	end

	// digit index 0 = digit one ... 3 = digit four
	wire [3:0] cpu_we = cs_rise ? fsd_addr_onehot(hold_addr_r) : 4'h0;
	logic [3:0] stb_d_r;
	wire [3:0] mux_we = stb_r & ~stb_d_r;
	wire [3:0] digit_we = (FRONT == FSD_FRONT_CPU) ? cpu_we : mux_we;
	wire fsd_seg_t cpu_pat = fsd_decode(hold_val_r, DECODE);
	wire fsd_seg_t mux_pat = fsd_decode(val_r, DECODE);
	wire fsd_seg_t new_pat = (FRONT == FSD_FRONT_CPU) ? cpu_pat : mux_pat;

	fsd_seg_t digit_r [4];

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			stb_d_r <= 4'h0;
			for (int i = 0; i < 4; i++) begin
				digit_r[i] <= `FSD_SEG_RESET;
			end
		end else if (i_ce) begin
			stb_d_r <= stb_r;
			for (int i = 0; i < 4; i++) begin
				if (digit_we[i]) begin
					digit_r[i] <= new_pat;
				end
			end
		end
	end

	// held-low detect on the timebase pin, filtered against short low phases
	logic [SLOW_W-1:0] low_cnt_r;
	logic slave_r;
	wire low_full = (low_cnt_r == SLOW_W'(`FSD_SLAVE_LOW_CYC));

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			low_cnt_r <= '0;
			slave_r <= 1'b0;
		end else if (i_ce) begin
			if (tb_sync) begin
				low_cnt_r <= '0;
				slave_r <= 1'b0;
			end else if (!low_full) begin
				low_cnt_r <= low_cnt_r + SLOW_W'(1);
			end else begin
				slave_r <= 1'b1;
			end
		end
	end

	// divide timebase rising edges by 128: a 64-edge half period
	logic tb_d_r;
	logic [DIV_W-1:0] div_r;
	wire tb_rise = tb_sync & ~tb_d_r;

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			// matches the synchronised reset level of the pin, so no false edge after reset
			tb_d_r <= 1'b1;
			div_r <= '0;
		end else if (i_ce) begin
			tb_d_r <= tb_sync;
			if (tb_rise) begin
				div_r <= div_r + DIV_W'(1);
			end
		end
	end

	// in slave mode the segment phase follows the backplane pin
	wire bp_phase = slave_r ? bp_in_sync : div_r[DIV_W-1];
	wire [27:0] lit = {digit_r[3], digit_r[2], digit_r[1], digit_r[0]};
	// led outputs are active-high drive enables; the brightness pin gates them all
	wire [27:0] seg_nxt = LED_VARIANT ? (lit & {28{bright_sync}}) : (lit ^ {28{bp_phase}});

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_segment <= 28'h0000000;
			o_backplane <= 1'b0;
			o_backplane_oe_n <= 1'b1;
		end else if (i_ce) begin
			o_segment <= seg_nxt;
			o_backplane <= div_r[DIV_W-1];
			o_backplane_oe_n <= LED_VARIANT | slave_r;
		end
	end

	a_slave_needs_low: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		$rose(slave_r) |-> $past(low_full)) else $error("slave mode entered without full low time");

	a_slave_releases_bp: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_ce && slave_r && !LED_VARIANT) |=> o_backplane_oe_n) else $error("backplane driven in slave mode");

	a_write_only_addr: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_ce && FRONT == FSD_FRONT_CPU && cs_rise) |=> digit_r[~hold_addr_r] == $past(cpu_pat))
		else $error("addressed digit not written");

	a_hold_no_write: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_ce && digit_we == 4'h0) |=> $stable(lit)) else $error("digit changed without write");

	a_lcd_phase: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_ce && !LED_VARIANT) |=> o_segment == ($past(lit) ^ {28{$past(bp_phase)}}))
		else $error("lcd segment phase wrong");

	a_led_blank: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_ce && LED_VARIANT && !bright_sync) |=> o_segment == 28'h0000000) else $error("led not blanked");

	a_div_half: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_ce && tb_rise && div_r == '1) |=> div_r[DIV_W-1] == 1'b0) else $error("divider wrap wrong");

	a_capture_both: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_ce && sel_both) |=> hold_val_r == $past(val_r) && hold_addr_r == $past(addr_r))
		else $error("holding latch missed capture");

	a_addr_digit_four: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_ce && FRONT == FSD_FRONT_CPU && cs_rise && hold_addr_r == `FSD_ADDR_DIGIT4) |-> digit_we == 4'h8)
		else $error("address zero did not pick digit four");

	a_addr_digit_three: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_ce && FRONT == FSD_FRONT_CPU && cs_rise && hold_addr_r == `FSD_ADDR_DIGIT3) |-> digit_we == 4'h4)
		else $error("address one did not pick digit three");

	a_addr_digit_two: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_ce && FRONT == FSD_FRONT_CPU && cs_rise && hold_addr_r == `FSD_ADDR_DIGIT2) |-> digit_we == 4'h2)
		else $error("address two did not pick digit two");

	a_addr_digit_one: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_ce && FRONT == FSD_FRONT_CPU && cs_rise && hold_addr_r == `FSD_ADDR_DIGIT1) |-> digit_we == 4'h1)
		else $error("address three did not pick digit one");

	a_write_spares_rest: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_ce && FRONT == FSD_FRONT_CPU && cs_rise && hold_addr_r == `FSD_ADDR_DIGIT1) |=> lit[27:7] == $past(lit[27:7]))
		else $error("write to digit one disturbed other digits");

	a_hold_keep: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_ce && !sel_both) |=> hold_val_r == $past(hold_val_r) && hold_addr_r == $past(hold_addr_r))
		else $error("holding latch moved while deselected");

	a_mux_store_one: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_ce && FRONT == FSD_FRONT_MUX && stb_r[0] && !stb_d_r[0]) |=> digit_r[0] == $past(mux_pat))
		else $error("strobe one did not store digit one");

	a_mux_store_four: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_ce && FRONT == FSD_FRONT_MUX && stb_r[3] && !stb_d_r[3]) |=> digit_r[3] == $past(mux_pat))
		else $error("strobe four did not store digit four");

	wire mux_codeb = (FRONT == FSD_FRONT_MUX) && (DECODE == FSD_DECODE_CODEB);
	a_codeb_dash: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_ce && mux_codeb && mux_we[2] && val_r == 4'hA) |=> digit_r[2] == 7'h40)
		else $error("code b ten is not a dash");

	a_codeb_blank: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_ce && mux_codeb && mux_we[3] && val_r == 4'hF) |=> digit_r[3] == 7'h00)
		else $error("code b fifteen is not blank");

	a_decimal_eight: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_ce && mux_codeb && mux_we[0] && val_r == 4'h8) |=> digit_r[0] == 7'h7F)
		else $error("eight not shown as all segments");

	a_div_step: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_ce && tb_rise) |=> div_r == DIV_W'($past(div_r) + 1'b1))
		else $error("divider did not count timebase edge");

	a_bp_from_div: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_ce) |=> o_backplane == $past(div_r[DIV_W-1]))
		else $error("backplane not from divider top bit");

	a_slave_exit: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_ce && tb_sync) |=> !slave_r)
		else $error("slave mode kept with timebase high");

	a_master_drives: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_ce && !LED_VARIANT && !slave_r) |=> !o_backplane_oe_n)
		else $error("master not driving backplane");

	a_slave_phase: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_ce && !LED_VARIANT && slave_r) |=> o_segment == ($past(lit) ^ {28{$past(bp_in_sync)}}))
		else $error("slave segments not timed from backplane pin");

	a_low_no_slave: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_ce && !low_full && !slave_r) |=> !slave_r)
		else $error("short low entered slave mode");

	a_led_full: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_ce && LED_VARIANT && bright_sync) |=> o_segment == $past(lit))
		else $error("led not fully lit when enabled");
endmodule

// ==== design/fsd_consts.svh ====
// constants for the four-digit segment decoder latch
// assumes a 250 MHz reference clock; all pins arrive asynchronously
`ifndef FSD_CONSTS_SVH
`define FSD_CONSTS_SVH
`define FSD_CLK_PERIOD_NS 4
`define FSD_SLAVE_LOW_NS 1000
`define FSD_SLAVE_LOW_CYC ((`FSD_SLAVE_LOW_NS + `FSD_CLK_PERIOD_NS - 1) / `FSD_CLK_PERIOD_NS)
`define FSD_BP_DIV 128
`define FSD_ADDR_DIGIT4 2'h0
`define FSD_ADDR_DIGIT3 2'h1
`define FSD_ADDR_DIGIT2 2'h2
`define FSD_ADDR_DIGIT1 2'h3
`define FSD_SEG_RESET 7'h00
`endif

// ==== design/fsd_pkg.sv ====
// types for the four-digit segment decoder latch
// used together with fsd_consts.svh
package fsd_pkg;
	typedef logic [6:0] fsd_seg_t;
	typedef enum logic {FSD_FRONT_MUX, FSD_FRONT_CPU} fsd_front_t;
	typedef enum logic {FSD_DECODE_HEX, FSD_DECODE_CODEB} fsd_decode_t;
endpackage

// ==== verification/fsd_host_model.sv ====
// host-side model of the processor write port
// assumes one write at a time, launched from the bench by a task call
module fsd_host_model (
	input wire logic i_clk,
	output logic [3:0] o_value,
	output logic o_digit_addr_low,
	output logic o_digit_addr_high,
	output logic o_chip_select_first_n,
	output logic o_chip_select_second_n
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		o_value = 4'h0;
		{o_digit_addr_high, o_digit_addr_low} = 2'h0;
		o_chip_select_first_n = 1'b1;
		o_chip_select_second_n = 1'b1;
	end
	task automatic write(input logic [1:0] addr, input logic [3:0] val, input bit second_first, input int hold);
		@(posedge i_clk);
		#1 o_value = val;
		{o_digit_addr_high, o_digit_addr_low} = addr;
		repeat (4) @(posedge i_clk);
		#1 o_chip_select_first_n = 1'b0;
		o_chip_select_second_n = 1'b0;
		repeat (hold) @(posedge i_clk);
		// either select may end the write
		if (second_first) #1 o_chip_select_second_n = 1'b1;
		else #1 o_chip_select_first_n = 1'b1;
		repeat (2) @(posedge i_clk);
		#1 o_chip_select_first_n = 1'b1;
		o_chip_select_second_n = 1'b1;
		repeat (2) @(posedge i_clk);
		// bus released: stale data would hide a late capture
		#1 o_value = ~val;
		{o_digit_addr_high, o_digit_addr_low} = ~addr;
	endtask
endmodule

// ==== verification/tb_top.sv ====
// self-checking bench for the segment decoder latch, lcd hex build and led code b build
// processor front end on the lcd build; slave mode first, then free-running timebase
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import fsd_pkg::*;
	logic i_ref_clk = 1'b0, i_rst = 1'b1, timebase = 1'b0, bp_in = 1'b0, run_osc = 1'b0;
	logic [3:0] value;
	logic a_lo, a_hi, cs1_n, cs2_n, o_bp, oe_n;
	logic [27:0] seg, model = 28'h0;
	logic [27:0] seg_led, led_model = 28'h0;
	logic [3:0] mux_val = 4'h0, strobe = 4'h0;
	logic bright = 1'b1, oe_led;
	logic [7:0] lfsr = 8'h10;
	logic [1:0] a;
	logic [3:0] v;
	logic [6:0] hex_tab [16] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07,
		7'h7F, 7'h6F, 7'h77, 7'h7C, 7'h39, 7'h5E, 7'h79, 7'h71};
	logic [6:0] codeb_tab [16] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07,
		7'h7F, 7'h6F, 7'h40, 7'h79, 7'h76, 7'h38, 7'h73, 7'h00};
	int bad_count = 0, total_checks = 0, cycles = 0, tb_edges = 0, n0;
	fsd_host_model host (.i_clk(i_ref_clk), .o_value(value), .o_digit_addr_low(a_lo),
		.o_digit_addr_high(a_hi), .o_chip_select_first_n(cs1_n), .o_chip_select_second_n(cs2_n));
	fsd_top #(.FRONT(FSD_FRONT_CPU), .DECODE(FSD_DECODE_HEX), .LED_VARIANT(1'b0)) uut (
		.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_ce(1'b1), .i_value(value),
		.i_digit_addr_low(a_lo), .i_digit_addr_high(a_hi), .i_chip_select_first_n(cs1_n),
		.i_chip_select_second_n(cs2_n), .i_digit_strobe(4'h0), .i_timebase_pin(timebase),
		.i_backplane(bp_in), .i_brightness(1'b1), .o_backplane(o_bp), .o_backplane_oe_n(oe_n),
		.o_segment(seg));
	// second build: strobed front end, code b, led outputs
	fsd_top #(.FRONT(FSD_FRONT_MUX), .DECODE(FSD_DECODE_CODEB), .LED_VARIANT(1'b1)) uut_led (
		.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_ce(1'b1), .i_value(mux_val),
		.i_digit_addr_low(1'b0), .i_digit_addr_high(1'b0), .i_chip_select_first_n(1'b1),
		.i_chip_select_second_n(1'b1), .i_digit_strobe(strobe), .i_timebase_pin(timebase),
		.i_backplane(bp_in), .i_brightness(bright), .o_backplane(), .o_backplane_oe_n(oe_led),
		.o_segment(seg_led));
	initial forever #2 i_ref_clk = ~i_ref_clk;
	// lows of 8 ns stay far below the slave detect time
	initial begin
		wait (run_osc);
		forever begin
			repeat (2) @(posedge i_ref_clk);
			#1 timebase = ~timebase;
		end
	end
	always @(posedge timebase) tb_edges++;
	always @(posedge i_ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			report_and_stop();
		end
	end
	function automatic logic [7:0] next_lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic check(input logic [27:0] seen, input logic [27:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic mux_write(input logic [1:0] d, input logic [3:0] v);
		@(posedge i_ref_clk);
		#1 mux_val = v;
		repeat (3) @(posedge i_ref_clk);
		#1 strobe[d] = 1'b1;
		repeat (4) @(posedge i_ref_clk);
		#1 strobe = 4'h0;
		repeat (6) @(posedge i_ref_clk);
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge i_ref_clk);
		#1 i_rst = 1'b0;
		repeat (300) @(posedge i_ref_clk);
		check({27'h0, oe_n}, 28'h1);
		for (int i = 0; i < 24; i++) begin
			a = (i < 4) ? i[1:0] : lfsr[1:0];
			v = (i < 16) ? i[3:0] : lfsr[5:2];
			lfsr = next_lfsr(lfsr);
			host.write(a, v, i[0], i[1] ? 12 : 5);
			model[7 * (3 - int'(a)) +: 7] = hex_tab[v];
			repeat (10) @(posedge i_ref_clk);
			check(seg, model);
		end
		$display("test write walk done");
		for (int k = 0; k < 16; k++) begin
			mux_write(k[1:0], k[3:0]);
			led_model[7 * int'(k[1:0]) +: 7] = codeb_tab[k];
			check(seg_led, led_model);
		end
		check({27'h0, oe_led}, 28'h1);
		for (int k = 0; k < 6; k++) begin
			@(posedge i_ref_clk);
			#1 bright = k[0];
			repeat (6) @(posedge i_ref_clk);
			check(seg_led, bright ? led_model : 28'h0);
		end
		$display("test led mux done");
		// one slow step from an outside source that all slaves share
		#1 bp_in = 1'b1;
		repeat (8) @(posedge i_ref_clk);
		check(seg, ~model);
		$display("test slave phase done");
		run_osc = 1'b1;
		repeat (40) @(posedge i_ref_clk);
		check({27'h0, oe_n}, 28'h0);
		@(o_bp);
		n0 = tb_edges;
		@(o_bp);
		check(28'(tb_edges - n0), 28'h40);
		repeat (20) @(posedge i_ref_clk);
		check(seg, model ^ {28{o_bp}});
		check({27'h0, oe_n}, 28'h0);
		$display("test master backplane done");
		report_and_stop();
	end
endmodule
